// ### bench/dtx_host_chk.sv
// dtx_host_chk: port checks of host bus and steering
// assumes bound to dtx_host_steering, single clock
`timescale 1ns/1ps
`default_nettype none
module dtx_host_chk #(
  parameter int unsigned BURST_CYCLES  = 8,
  parameter int unsigned SETTLE_CYCLES = 3
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_separate_strobes,
  input wire logic i_chip_select_n,
  input wire logic i_read_write,
  input wire logic i_data_or_read_strobe,
  input wire logic o_host_data_nibble_oe_n,
  input wire logic o_interrupt_or_progress_out,
  input wire logic i_pair_valid,
  input wire logic o_early_tone_detect,
  input wire logic i_steering_in_guard_out,
  input wire logic o_steering_in_guard_out,
  input wire logic o_steering_in_guard_oe_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire logic rd_on = !i_chip_select_n &&
    (i_separate_strobes ? !i_data_or_read_strobe : (i_data_or_read_strobe && i_read_write));
  // pair held through settle, so guard must still drive
  sequence s_pair_held;
    $rose(i_steering_in_guard_out) && i_pair_valid ##1 (i_steering_in_guard_out && i_pair_valid)[*6];
  endsequence
  a_bus_quiet: assert property (!rd_on |=> o_host_data_nibble_oe_n)
    else $error("data bus driven outside a read");
  a_write_quiet: assert property (!i_chip_select_n && !i_read_write && i_data_or_read_strobe
    |=> o_host_data_nibble_oe_n)
    else $error("data bus driven during a write");
  a_read_drives: assert property (rd_on |=> !o_host_data_nibble_oe_n)
    else $error("selected read not driven");
  a_early_rise: assert property ($rose(i_pair_valid) |=> o_early_tone_detect)
    else $error("early detect late");
  a_early_drop: assert property (!i_pair_valid |=> !o_early_tone_detect)
    else $error("early detect held after loss");
  a_guard_tracks: assert property (!o_steering_in_guard_oe_n
    |-> o_steering_in_guard_out == $past(i_pair_valid))
    else $error("guard level wrong");
  a_guard_holds: assert property (s_pair_held |=> !o_steering_in_guard_oe_n && o_steering_in_guard_out)
    else $error("guard released while pair held");
  a_drain_low: assert property (o_interrupt_or_progress_out == 1'h0)
    else $error("open drain output driven high");
endmodule : dtx_host_chk
bind dtx_host_steering dtx_host_chk #(.BURST_CYCLES(BURST_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_separate_strobes(i_separate_strobes),
  .i_chip_select_n(i_chip_select_n), .i_read_write(i_read_write),
  .i_data_or_read_strobe(i_data_or_read_strobe), .o_host_data_nibble_oe_n(o_host_data_nibble_oe_n),
  .o_interrupt_or_progress_out(o_interrupt_or_progress_out), .i_pair_valid(i_pair_valid),
  .o_early_tone_detect(o_early_tone_detect), .i_steering_in_guard_out(i_steering_in_guard_out),
  .o_steering_in_guard_out(o_steering_in_guard_out), .o_steering_in_guard_oe_n(o_steering_in_guard_oe_n));
`default_nettype wire

// ### bench/dtx_host_model.sv
// dtx_host_model: host controller on the four-bit bus
// assumes signals change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module dtx_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_data_oe_n,
  input  wire logic [3:0] i_data,
  output var  logic       o_sep,
  output var  logic       o_cs_n,
  output var  logic       o_rs,
  output var  logic       o_rw,
  output var  logic       o_ds,
  output var  logic [3:0] o_data
);
  initial begin
    o_sep = 1'h0;
    o_cs_n = 1'h1;
    o_rs = 1'h0;
    o_rw = 1'h1;
    o_ds = 1'h0;
    o_data = 4'h0;
  end
  task automatic use_sep(input logic s);
    @(posedge i_clock);
    #1;
    o_sep = s;
    o_ds = s;
  endtask : use_sep
  task automatic access(input logic rd, input logic rs, input logic cs_n, input logic [3:0] d,
                        output logic [3:0] q, output logic oe_n);
    @(posedge i_clock);
    #1;
    o_cs_n = cs_n;
    o_rs = rs;
    o_rw = rd;
    o_ds = o_sep ? !rd : 1'h1;
    o_data = rd ? ~o_data : d;
    @(posedge i_clock);
    // sample mid cycle, where the registered read data has settled
    @(negedge i_clock);
    q = i_data;
    oe_n = i_data_oe_n;
    @(posedge i_clock);
    #1;
    o_cs_n = 1'h1;
    o_rw = 1'h1;
    o_ds = o_sep;
    // released lines show the inverse, not a stale value
    o_data = ~o_data;
  endtask : access
endmodule : dtx_host_model
`default_nettype wire

// ### bench/tb_top.sv
// tb_top: scenario bench for host port and steering
// assumes host model drives the bus; bench plays detector and steering pin
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rstn, pv, prog, st, sep, cs_n, rs, rw, ds, d_oe_n, irq, irq_oe_n, early, g_out, g_oe_n, tone, oe;
  logic [1:0] lo, hi;
  logic [3:0] h_d, d_out, bus, q, t_code;
  int err_total, compares, n;
  localparam logic [3:0] digit [16] = '{4'h1, 4'h2, 4'h3, 4'hd, 4'h4, 4'h5, 4'h6, 4'he,
                                       4'h7, 4'h8, 4'h9, 4'hf, 4'hb, 4'ha, 4'hc, 4'h0};
  assign bus = d_oe_n ? h_d : d_out;
  dtx_host_steering #(.BURST_CYCLES(8), .SETTLE_CYCLES(3)) u_dut (.i_clock(clk), .i_rstn(rstn),
    .i_separate_strobes(sep), .i_chip_select_n(cs_n), .i_register_select(rs), .i_read_write(rw),
    .i_data_or_read_strobe(ds), .i_host_data_nibble(bus), .o_host_data_nibble(d_out),
    .o_host_data_nibble_oe_n(d_oe_n), .o_interrupt_or_progress_out(irq),
    .o_interrupt_or_progress_oe_n(irq_oe_n), .i_pair_valid(pv), .i_low_group(lo), .i_high_group(hi),
    .i_progress_level(prog), .o_early_tone_detect(early), .i_steering_in_guard_out(st),
    .o_steering_in_guard_out(g_out), .o_steering_in_guard_oe_n(g_oe_n), .o_tone_on(tone), .o_tone_code(t_code));
  dtx_host_model u_host (.i_clock(clk), .i_data_oe_n(d_oe_n), .i_data(d_out), .o_sep(sep), .o_cs_n(cs_n),
    .o_rs(rs), .o_rw(rw), .o_ds(ds), .o_data(h_d));
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic test_done();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic t_strobes();
    check(4'(d_oe_n), 4'h1);
    u_host.access(1'h1, 1'h1, 1'h0, 4'h0, q, oe);
    check(q, 4'h2);
    check(4'(oe), 4'h0);
    u_host.access(1'h0, 1'h1, 1'h0, 4'h1, q, oe);
    u_host.access(1'h0, 1'h1, 1'h1, 4'h0, q, oe);
    check(4'(tone), 4'h1);
    u_host.use_sep(1'h1);
    u_host.access(1'h1, 1'h1, 1'h1, 4'h0, q, oe);
    check(4'(oe), 4'h1);
    u_host.access(1'h0, 1'h1, 1'h0, 4'h4, q, oe);
    tick(2);
    check(4'(tone), 4'h0);
  endtask : t_strobes
  task automatic t_digits();
    for (n = 0; n < 16; n++) begin
      {lo, hi} = 4'(n);
      pv = 1'h1;
      tick(2);
      check(4'(early), 4'h1);
      st = 1'h1;
      tick(8);
      check(4'(irq_oe_n), 4'h0);
      check(4'({g_oe_n, g_out}), 4'h1);
      u_host.access(1'h1, 1'h0, 1'h0, 4'h0, q, oe);
      check(q, digit[n]);
      u_host.access(1'h1, 1'h1, 1'h0, 4'h0, q, oe);
      check(4'(q[3]), 4'h1);
      pv = 1'h0;
      st = 1'h0;
      tick(3);
      check(4'({early, irq_oe_n}), 4'h1);
    end
    {lo, hi} = 4'h1;
    pv = 1'h1;
    tick(2);
    st = 1'h1;
    tick(1);
    st = 1'h0;
    pv = 1'h0;
    tick(8);
    u_host.access(1'h1, 1'h0, 1'h0, 4'h0, q, oe);
    check(q, 4'h0);
  endtask : t_digits
  task automatic t_burst();
    u_host.use_sep(1'h0);
    u_host.access(1'h0, 1'h1, 1'h0, 4'hd, q, oe);
    u_host.access(1'h0, 1'h0, 1'h0, 4'h5, q, oe);
    for (n = 0; n < 20 && tone !== 1'h1; n++) tick(1);
    check(4'(n < 20), 4'h1);
    for (n = 0; n < 12 && tone === 1'h1; n++) tick(1);
    check(4'(n), 4'h8);
    check(4'(irq_oe_n), 4'h1);
    check(t_code, 4'h5);
    for (n = 0; n < 40 && irq_oe_n !== 1'h0; n++) tick(1);
    check(4'(n >= 7 && n <= 11), 4'h1);
    u_host.access(1'h1, 1'h1, 1'h0, 4'h0, q, oe);
    check(q, 4'h3);
  endtask : t_burst
  task automatic t_cp();
    u_host.access(1'h0, 1'h1, 1'h0, 4'h2, q, oe);
    tick(2);
    check(4'(irq_oe_n), 4'h0);
    prog = 1'h1;
    tick(2);
    check(4'(irq_oe_n), 4'h1);
    check(4'(irq), 4'h0);
  endtask : t_cp
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rstn, pv, prog, st, lo, hi} = 8'h0;
    err_total = 0;
    compares = 0;
    tick(16);
    rstn = 1'h1;
    t_strobes();
    t_digits();
    t_burst();
    t_cp();
    test_done();
  end
endmodule : tb_top
`default_nettype wire

// ### verilog/dtx_burst_if.sv
// dtx_burst_if: control and status between the host port and the burst timer
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface dtx_burst_if;
  logic start;
  logic burst_mode;
  logic tone_enable;
  logic tone_on;
  logic done;
  modport ctrl  (output start, output burst_mode, output tone_enable, input tone_on, input done);
  modport timer (input start, input burst_mode, input tone_enable, output tone_on, output done);
endinterface : dtx_burst_if
`default_nettype wire

// ### verilog/dtx_burst_timer.sv
// dtx_burst_timer: tone burst and pause counter
// assumes start is a one-cycle pulse from the host port
`timescale 1ns/1ps
`default_nettype none
module dtx_burst_timer #(
  parameter int unsigned BURST_CYCLES = dtx_pkg::burst_cycles
) (
  input  wire logic  i_clock,
  input  wire logic  i_rstn,
  dtx_burst_if.timer bus
);
  localparam int unsigned cw = $clog2(BURST_CYCLES + 1);
  localparam logic [cw-1:0] last = cw'(BURST_CYCLES - 1);

  dtx_pkg::dtx_burst_state_type state;
  dtx_pkg::dtx_burst_state_type next_state;
  logic [cw-1:0] count;
  wire           count_end = (count == last);
  wire           burst_go  = bus.start && bus.burst_mode && bus.tone_enable;

  always_comb begin
    next_state = state;
    unique case (state)
      dtx_pkg::dtx_idle:  if (burst_go) next_state = dtx_pkg::dtx_tone;
      dtx_pkg::dtx_tone:  if (count_end) next_state = dtx_pkg::dtx_pause;
      dtx_pkg::dtx_pause: if (count_end) next_state = dtx_pkg::dtx_idle;
      default:            next_state = dtx_pkg::dtx_idle;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= dtx_pkg::dtx_idle;
      count <= '0;
      bus.done <= 1'b0;
    end else begin
      state <= next_state;
      count <= (state != next_state || state == dtx_pkg::dtx_idle) ? '0 : count + 1'b1;
      bus.done <= (state == dtx_pkg::dtx_pause) && count_end;
    end
  end

  // outside burst mode the tone simply follows the enable bit
  assign bus.tone_on = bus.burst_mode ? (state == dtx_pkg::dtx_tone) : bus.tone_enable;
endmodule : dtx_burst_timer
`default_nettype wire

// ### verilog/dtx_host_steering.sv
// dtx_host_steering: four-bit host port, steering and interrupt logic
// assumes all pins synchronous to i_clock; analog detector supplies group indices
`timescale 1ns/1ps
`default_nettype none
module dtx_host_steering #(
  parameter int unsigned BURST_CYCLES  = dtx_pkg::burst_cycles,
  parameter int unsigned SETTLE_CYCLES = dtx_pkg::settle_cycles
) (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  input  wire logic       i_separate_strobes,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_register_select,
  input  wire logic       i_read_write,
  input  wire logic       i_data_or_read_strobe,
  input  wire logic [3:0] i_host_data_nibble,
  output logic      [3:0] o_host_data_nibble,
  output logic            o_host_data_nibble_oe_n,
  output logic            o_interrupt_or_progress_out,
  output logic            o_interrupt_or_progress_oe_n,
  input  wire logic       i_pair_valid,
  input  wire logic [1:0] i_low_group,
  input  wire logic [1:0] i_high_group,
  input  wire logic       i_progress_level,
  output logic            o_early_tone_detect,
  input  wire logic       i_steering_in_guard_out,
  output logic            o_steering_in_guard_out,
  output logic            o_steering_in_guard_oe_n,
  output logic            o_tone_on,
  output logic      [3:0] o_tone_code
);
  // host access decode; chip select already qualified by the host
  wire sel         = !i_chip_select_n;
  wire rd_strobe   = i_separate_strobes ? !i_data_or_read_strobe
                                        : (i_data_or_read_strobe && i_read_write);
  wire wr_strobe   = i_separate_strobes ? !i_read_write
                                        : (i_data_or_read_strobe && !i_read_write);
  // limitation: the bus enable is registered, so it lets go one clock after the strobe
  wire rd_active   = sel && rd_strobe;
  wire wr_active   = sel && wr_strobe;

  logic       wr_prev;
  logic       rd_prev;
  logic       rd_sel_prev;
  logic [3:0] ctrl;
  logic [3:0] tx_code;
  logic       tx_empty;
  logic [3:0] rx_code;
  logic       rx_full;
  logic       dst;
  logic       irq_pending;
  logic       st_prev;
  logic       settle_busy;
  logic [7:0] settle_count;
  logic [3:0] pending_code;

  wire wr_take     = wr_active && !wr_prev;
  wire rd_end      = rd_prev && !rd_active;
  wire wr_data     = wr_take && (i_register_select == dtx_pkg::sel_data);
  wire wr_ctrl     = wr_take && (i_register_select == dtx_pkg::sel_ctrl);
  wire read_data   = rd_end && (rd_sel_prev == dtx_pkg::sel_data);
  wire read_status = rd_end && (rd_sel_prev == dtx_pkg::sel_ctrl);

  // digit code from tone group indices; low groups 697/770/852/941, high 1209/1336/1477/1633
  function automatic logic [3:0] digit_code(input logic [1:0] lo, input logic [1:0] hi);
    logic [3:0] c;
    c = 4'h0;
    if (hi == 2'h3)
      c = (lo == 2'h3) ? 4'h0 : 4'(4'hd + {2'h0, lo});
    else if (lo == 2'h3)
      c = (hi == 2'h0) ? 4'hb : ((hi == 2'h1) ? 4'ha : 4'hc);
    else
      c = 4'({lo, 2'h0} - {2'h0, lo} + {2'h0, hi} + 4'h1);
    return c;
  endfunction : digit_code

  // steering: register on the rise above threshold only
  wire st_rise     = i_steering_in_guard_out && !st_prev;
  wire st_low      = !i_steering_in_guard_out;
  wire settle_done = settle_busy && (settle_count == 8'(SETTLE_CYCLES - 1));

  // status nibble placed by the package bit positions
  wire [3:0] status_word;
  assign status_word[dtx_pkg::sts_irq]      = irq_pending;
  assign status_word[dtx_pkg::sts_tx_empty] = tx_empty;
  assign status_word[dtx_pkg::sts_rx_full]  = rx_full;
  assign status_word[dtx_pkg::sts_dst]      = dst;
  wire [3:0] read_word   = (i_register_select == dtx_pkg::sel_data) ? rx_code : status_word;
  wire       tx_done;
  wire       tone_en     = ctrl[dtx_pkg::ctl_tone_en];
  wire       burst_en    = ctrl[dtx_pkg::ctl_burst];
  wire       irq_en      = ctrl[dtx_pkg::ctl_irq_en];
  wire       cp_mode     = ctrl[dtx_pkg::ctl_cp_mode];
  wire       irq_low     = irq_en && (irq_pending || dst);

  // next values of the flags; a setting event wins over its clear, except tx_empty, where a data write wins over tx_done
  wire       next_rd_sel      = rd_active ? i_register_select : rd_sel_prev;
  // a write in the same cycle as completion keeps the buffer full
  wire       next_tx_empty    = wr_data ? 1'b0 : (tx_done || tx_empty);
  wire       next_settle_busy = st_rise || (settle_busy && !settle_done && !st_low);
  wire       next_dst         = settle_done || (dst && !st_low);
  wire       next_rx_full     = settle_done || (rx_full && !read_data);
  wire       next_irq_pending = settle_done || tx_done || (irq_pending && !read_status);

  dtx_burst_if burst_bus ();
  assign burst_bus.start       = wr_data;
  assign burst_bus.burst_mode  = burst_en;
  assign burst_bus.tone_enable = tone_en;
  assign tx_done               = burst_bus.done;

  dtx_burst_timer #(
    .BURST_CYCLES (BURST_CYCLES)
  ) u_burst (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .bus     (burst_bus.timer)
  );

  // host port state
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_prev     <= 1'b0;
      rd_prev     <= 1'b0;
      rd_sel_prev <= 1'b0;
      ctrl        <= dtx_pkg::ctl_reset;
      tx_code     <= 4'h0;
      tx_empty    <= 1'b1;
    end else begin
      wr_prev     <= wr_active;
      rd_prev     <= rd_active;
      rd_sel_prev <= next_rd_sel;
      if (wr_ctrl) ctrl <= i_host_data_nibble;
      if (wr_data) tx_code <= i_host_data_nibble;
      tx_empty    <= next_tx_empty;
    end
  end

  // receive steering and delayed steering
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st_prev      <= 1'b0;
      settle_busy  <= 1'b0;
      settle_count <= 8'h0;
      pending_code <= 4'h0;
      rx_code      <= 4'h0;
      rx_full      <= 1'b0;
      dst          <= 1'b0;
    end else begin
      st_prev      <= i_steering_in_guard_out;
      if (st_rise) pending_code <= digit_code(i_low_group, i_high_group);
      settle_busy  <= next_settle_busy;
      settle_count <= settle_busy ? settle_count + 8'h1 : 8'h0;
      if (settle_done) rx_code <= pending_code;
      dst          <= next_dst;
      rx_full      <= next_rx_full;
    end
  end

  // interrupt: events win over a clearing status read
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_pending <= 1'b0;
    end else begin
      irq_pending <= next_irq_pending;
    end
  end

  // pin drivers, all registered; one short block per pin group
  wire data_drive_n  = !rd_active;
  wire irq_drive_n   = cp_mode ? i_progress_level : !irq_low;
  // guard drives toward early detect whenever the sensed level disagrees
  wire guard_hold    = i_pair_valid && (dst || settle_busy || st_rise);
  wire guard_differs = i_pair_valid != i_steering_in_guard_out;
  wire guard_drive_n = !(guard_hold || guard_differs);

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_host_data_nibble      <= 4'h0;
      o_host_data_nibble_oe_n <= 1'b1;
    end else begin
      o_host_data_nibble      <= read_word;
      o_host_data_nibble_oe_n <= data_drive_n;
    end
  end

  // open drain: the level is tied low, only the enable moves
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_interrupt_or_progress_out  <= 1'b0;
      o_interrupt_or_progress_oe_n <= 1'b1;
    end else begin
      o_interrupt_or_progress_out  <= 1'b0;
      o_interrupt_or_progress_oe_n <= irq_drive_n;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_early_tone_detect <= 1'b0;
    end else begin
      o_early_tone_detect <= i_pair_valid;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_steering_in_guard_out  <= 1'b0;
      o_steering_in_guard_oe_n <= 1'b1;
    end else begin
      o_steering_in_guard_out  <= i_pair_valid;
      o_steering_in_guard_oe_n <= guard_drive_n;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tone_on   <= 1'b0;
      o_tone_code <= 4'h0;
    end else begin
      o_tone_on   <= burst_bus.tone_on;
      o_tone_code <= tx_code;
    end
  end
endmodule : dtx_host_steering
`default_nettype wire

// ### verilog/dtx_pkg.sv
// dtx_pkg: constants for the dtmf transceiver host port and steering logic
// assumes one 10 MHz system clock; the analog front end lives outside
package dtx_pkg;
  localparam int unsigned clock_hz       = 10_000_000;
  localparam int unsigned ref_khz        = 3580;
  localparam int unsigned burst_ms       = 51;
  localparam int unsigned burst_cycles   = (clock_hz / 1000) * burst_ms;
  localparam int unsigned settle_ns      = 300;
  localparam int unsigned settle_cycles  = (settle_ns * (clock_hz / 1_000_000) + 999) / 1000;

  // register select values
  localparam logic        sel_data       = 1'h0;
  localparam logic        sel_ctrl       = 1'h1;

  // control register bits
  localparam int unsigned ctl_tone_en    = 0;
  localparam int unsigned ctl_cp_mode    = 1;
  localparam int unsigned ctl_irq_en     = 2;
  localparam int unsigned ctl_burst      = 3;
  localparam logic [3:0]  ctl_reset      = 4'h0;

  // status register bits
  localparam int unsigned sts_irq        = 0;
  localparam int unsigned sts_tx_empty   = 1;
  localparam int unsigned sts_rx_full    = 2;
  localparam int unsigned sts_dst        = 3;

  typedef enum logic [1:0] {
    dtx_idle,
    dtx_tone,
    dtx_pause
  } dtx_burst_state_type;
endpackage : dtx_pkg
